// *** load_regs_pkg.sv ***
/*
  Shared types and constants of the status, measurement and setpoint object bank.
  Assumes one system clock and one asynchronous reset; no other file is needed.
*/
package load_regs_pkg;

  // Object indices of the bank.
  localparam logic [15:0] IDX_QUESTIONABLE_STATUS = 16'h200B;
  localparam logic [15:0] IDX_OPERATION_WORD0 = 16'h200D;
  localparam logic [15:0] IDX_OPERATION_WORD1 = 16'h200E;
  localparam logic [15:0] IDX_MEASURED_CURRENT = 16'h2101;
  localparam logic [15:0] IDX_MEASURED_VOLTAGE = 16'h2102;
  localparam logic [15:0] IDX_CURRENT_SETPOINT_WR = 16'h2201;
  localparam logic [15:0] IDX_CURRENT_SETPOINT_RD = 16'h2202;
  localparam logic [15:0] IDX_VOLTAGE_SETPOINT_WR = 16'h2203;
  localparam logic [15:0] IDX_VOLTAGE_SETPOINT_RD = 16'h2204;

  // Reset values.
  localparam logic [31:0] SETPOINT_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Regulation mode reported by the analog loop.
  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_CC,
    MODE_CV,
    MODE_CR,
    MODE_CP
  } reg_mode_t;

  // Object access request and answer.
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [31:0] wdata;
  } obj_req_t;

  typedef struct packed {
    logic done;
    logic fault;
    logic [31:0] rdata;
  } obj_rsp_t;

  // First operation-status word, bit 31 down to bit 0.
  typedef struct packed {
    logic spare31;
    logic target_upgrading;
    logic regulation_lost;
    logic below_min_volts;
    logic resistor_hot;
    logic line_fault;
    logic stack_overflow;
    logic config_mismatch;
    logic diode_hot;
    logic maintenance;
    logic spare21;
    logic safety_loop_open;
    logic aux_fuse_blown;
    logic linear_hot;
    logic volt_rating_exceeded;
    logic amp_rating_exceeded;
    logic comm_corrupt;
    logic phase_amps_high;
    logic target_start_pending;
    logic target_start_failed;
    logic resistor_power_limit;
    logic linear_power_limit;
    logic target_shutdown;
    logic low_volt_trip_flag;
    logic sense_out_of_bounds;
    logic watt_trip_flag;
    logic volt_trip_flag;
    logic amp_trip_flag;
    logic [1:0] spare3_2;
    logic output_live;
    logic output_standby;
  } op_word0_t;

  // Second operation-status word, bit 31 down to bit 0.
  typedef struct packed {
    logic [13:0] spare31_18;
    logic firmware_mismatch;
    logic rating_invalid;
    logic [7:0] spare15_8;
    logic transformer_hot;
    logic out_capacitor_hot;
    logic out_filter_hot;
    logic power_module_hot;
    logic spare3;
    logic fan_stalled;
    logic filter_fuse_blown;
    logic missing_phase;
  } op_word1_t;

  // Questionable-status word, bit 31 down to bit 0.
  typedef struct packed {
    logic [15:0] spare31_16;
    logic aux_input_fault;
    logic input_supply_lost;
    logic safety_loop_open;
    logic any_hard_fault;
    logic any_soft_fault;
    logic reg_const_watts;
    logic reg_const_ohms;
    logic reg_const_volts;
    logic reg_const_amps;
    logic sense_lost;
    logic temp_protect_hard;
    logic amp_protect_hard;
    logic watt_trip_soft;
    logic volt_trip_soft;
    logic amp_trip_soft;
    logic volt_protect_hard;
  } quest_word_t;

endpackage : load_regs_pkg

// *** load_status_setpoint_regs.sv ***
/*
  Status, measurement and setpoint object bank of a DC electronic load.
  Assumes the fieldbus engine presents one object access at a time on req and
  takes the answer on rsp; condition inputs and measurements are synchronous to clk.
*/
// What this block does
// RQ1 - Questionable-status object is read-only and follows live conditions without latching.
// RQ2 - Reading questionable status returns current value and clears nothing.
// RQ3 - Bits 0-6: VOLT_PROTECT_HARD, over-current, over-voltage, over-power trips, AMP_PROTECT_HARD, OTP, sense loss.
// RQ4 - Bits 7-10 show constant current, voltage, resistance, power regulation.
// RQ5 - Bit 11 is the OR of the three soft trip bits.
// RQ6 - Bit 12 is the OR of the four hard fault bits.
// RQ7 - Bits 13-15: interlock open, input power loss, analog/digital input fault.
// RQ8 - First operation-status object is read-only, live, and unchanged by reads.
// RQ9 - Word0 bit 0 means standby, bit 1 means output active.
// RQ10 - Word0 bits 4-8: current, voltage, power trips, sense out of bounds, undervoltage.
// RQ11 - Word0 bits 9-15: shutdown, power limits, boot faults, phase current, comms.
// RQ12 - Word0 bits 16, 17: terminal current, voltage over product rating.
// RQ13 - Word0 bits 18, 23, 27: linear, diode, resistor module over-temperature.
// RQ14 - Word0 bits 19,20,22,24,25,26,28,29,30 carry the remaining listed conditions.
// RQ15 - Questionable bits are derived from operation-status bits, bits 7-10 from reg_mode; layout stays fixed.
// RQ16 - Word1 bits 0-2: missing phase, input filter fuse, fan locked rotor.
// RQ17 - Word1 bits 4-7: power module, filter, capacitor, transformer temperature faults.
// RQ18 - Measured-current object returns average terminal current as a float.
// RQ19 - Measured voltage returns sense voltage when remote sense is engaged.
// RQ20 - Current setpoint is read/write and drives regulation in constant-current mode.
// RQ21 - Voltage setpoint is read/write and drives regulation in constant-voltage mode.
// RQ22 - Unused status bits read zero; host writes cannot influence them.
`timescale 1ns/1ps

module load_status_setpoint_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire load_regs_pkg::obj_req_t req,
  output load_regs_pkg::obj_rsp_t rsp,
  input wire load_regs_pkg::op_word0_t op0_cond,
  input wire load_regs_pkg::op_word1_t op1_cond,
  input wire load_regs_pkg::reg_mode_t reg_mode,
  input wire logic [31:0] terminal_amps,
  input wire logic [31:0] terminal_volts,
  input wire logic [31:0] sense_volts,
  input wire logic sense_engaged,
  output logic [31:0] current_setpoint,
  output logic [31:0] voltage_setpoint,
  output logic amp_loop_active,
  output logic volt_loop_active,
  output logic [31:0] loop_target_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Live status words.

  load_regs_pkg::op_word0_t word0;
  load_regs_pkg::op_word1_t word1;
  load_regs_pkg::quest_word_t quest;

  // Word0 carries the conditions as they stand; spare positions are forced low.
  always_comb begin
    word0 = op0_cond; // [RQ8] [RQ9] [RQ10] [RQ11] [RQ12] [RQ13] [RQ14]
    word0.spare31 = 1'b0; // [RQ22]
    word0.spare21 = 1'b0; // [RQ22]
    word0.spare3_2 = '0; // [RQ22]
  end

  // Word1 carries the conditions as they stand; spare positions are forced low.
  always_comb begin
    word1 = op1_cond; // [RQ16] [RQ17]
    word1.spare31_18 = '0; // [RQ22]
    word1.spare15_8 = '0; // [RQ22]
    word1.spare3 = 1'b0; // [RQ22]
  end

  // Questionable bits are drawn from the operation words and reg_mode, never latched.
  always_comb begin
    quest = '0; // [RQ22]
    quest.volt_protect_hard = word0.volt_rating_exceeded; // [RQ3] [RQ15]
    quest.amp_trip_soft = word0.amp_trip_flag; // [RQ3] [RQ15]
    quest.volt_trip_soft = word0.volt_trip_flag; // [RQ3] [RQ15]
    quest.watt_trip_soft = word0.watt_trip_flag; // [RQ3] [RQ15]
    quest.amp_protect_hard = word0.amp_rating_exceeded; // [RQ3] [RQ15]
    quest.temp_protect_hard = word0.linear_hot | word0.diode_hot | word0.resistor_hot
                              | word1.power_module_hot | word1.out_filter_hot
                              | word1.out_capacitor_hot | word1.transformer_hot; // [RQ3]
    quest.sense_lost = word0.sense_out_of_bounds; // [RQ3] [RQ15]
    quest.reg_const_amps = (reg_mode == load_regs_pkg::MODE_CC); // [RQ4]
    quest.reg_const_volts = (reg_mode == load_regs_pkg::MODE_CV); // [RQ4]
    quest.reg_const_ohms = (reg_mode == load_regs_pkg::MODE_CR); // [RQ4]
    quest.reg_const_watts = (reg_mode == load_regs_pkg::MODE_CP); // [RQ4]
    quest.any_soft_fault = quest.amp_trip_soft | quest.volt_trip_soft
                           | quest.watt_trip_soft; // [RQ5]
    quest.any_hard_fault = quest.volt_protect_hard | quest.amp_protect_hard
                           | quest.temp_protect_hard | quest.sense_lost; // [RQ6]
    quest.safety_loop_open = word0.safety_loop_open; // [RQ7] [RQ15]
    quest.input_supply_lost = word1.missing_phase | word1.filter_fuse_blown; // [RQ7]
    quest.aux_input_fault = word0.line_fault; // [RQ7] [RQ15]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Object decode.

  wire hit_quest = (req.index == load_regs_pkg::IDX_QUESTIONABLE_STATUS);
  wire hit_word0 = (req.index == load_regs_pkg::IDX_OPERATION_WORD0);
  wire hit_word1 = (req.index == load_regs_pkg::IDX_OPERATION_WORD1);
  wire hit_amps = (req.index == load_regs_pkg::IDX_MEASURED_CURRENT);
  wire hit_volts = (req.index == load_regs_pkg::IDX_MEASURED_VOLTAGE);
  wire hit_amp_set_wr = (req.index == load_regs_pkg::IDX_CURRENT_SETPOINT_WR);
  wire hit_amp_set_rd = (req.index == load_regs_pkg::IDX_CURRENT_SETPOINT_RD);
  wire hit_volt_set_wr = (req.index == load_regs_pkg::IDX_VOLTAGE_SETPOINT_WR);
  wire hit_volt_set_rd = (req.index == load_regs_pkg::IDX_VOLTAGE_SETPOINT_RD);

  wire hit_amp_set = hit_amp_set_wr | hit_amp_set_rd;
  wire hit_volt_set = hit_volt_set_wr | hit_volt_set_rd;
  wire hit_read_only = hit_quest | hit_word0 | hit_word1 | hit_amps | hit_volts
                       | hit_amp_set_rd | hit_volt_set_rd;
  wire hit_any = hit_read_only | hit_amp_set_wr | hit_volt_set_wr;

  // Writes land only on the two writable setpoint indices.
  wire wr_amp_set = req.valid & req.write & hit_amp_set_wr; // [RQ20]
  wire wr_volt_set = req.valid & req.write & hit_volt_set_wr; // [RQ21]

  // A write to a read-only or unknown index is refused and changes nothing.
  wire refused = ~hit_any | (req.write & hit_read_only); // [RQ22]

  ////////////////////////////////////////////////////////////////////////////////
  // Read data selection.

  wire [31:0] volts_shown = sense_engaged ? sense_volts : terminal_volts; // [RQ19]

  wire [31:0] read_value =
    hit_quest ? quest : // [RQ1] [RQ2]
    hit_word0 ? word0 : // [RQ8]
    hit_word1 ? word1 :
    hit_amps ? terminal_amps : // [RQ18]
    hit_volts ? volts_shown : // [RQ19]
    hit_amp_set ? current_setpoint : // [RQ20]
    hit_volt_set ? voltage_setpoint : // [RQ21]
    load_regs_pkg::RDATA_RESET;

  load_regs_pkg::obj_rsp_t rsp_d;

  always_comb begin
    rsp_d.done = req.valid;
    rsp_d.fault = req.valid & refused;
    rsp_d.rdata = (req.valid & ~req.write & ~refused) ? read_value
                                                     : load_regs_pkg::RDATA_RESET;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  load_regs_pkg::obj_rsp_t rsp_q;
  logic [31:0] amp_set_q;
  logic [31:0] volt_set_q;

  // Reads only sample the live words; nothing is cleared on a read.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d; // [RQ2]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      amp_set_q <= load_regs_pkg::SETPOINT_RESET;
    end else if (wr_amp_set) begin
      amp_set_q <= req.wdata; // [RQ20]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      volt_set_q <= load_regs_pkg::SETPOINT_RESET;
    end else if (wr_volt_set) begin
      volt_set_q <= req.wdata; // [RQ21]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Regulation target handed to the loop.

  wire [31:0] loop_target_d =
    (reg_mode == load_regs_pkg::MODE_CC) ? amp_set_q : // [RQ20]
    (reg_mode == load_regs_pkg::MODE_CV) ? volt_set_q : // [RQ21]
    load_regs_pkg::SETPOINT_RESET;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loop_target_q <= load_regs_pkg::SETPOINT_RESET;
    end else begin
      loop_target_q <= loop_target_d;
    end
  end

  assign rsp = rsp_q;
  assign current_setpoint = amp_set_q;
  assign voltage_setpoint = volt_set_q;
  assign amp_loop_active = (reg_mode == load_regs_pkg::MODE_CC); // [RQ20]
  assign volt_loop_active = (reg_mode == load_regs_pkg::MODE_CV); // [RQ21]

endmodule : load_status_setpoint_regs

// *** load_regs_sva.sv ***
/*
  Port checks of the object bank.
  Assumes it is bound to load_status_setpoint_regs and sees one clock domain.
*/
`timescale 1ns/1ps

module load_regs_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire load_regs_pkg::obj_req_t req,
  input wire load_regs_pkg::obj_rsp_t rsp,
  input wire load_regs_pkg::reg_mode_t reg_mode,
  input wire logic [31:0] current_setpoint,
  input wire logic [31:0] voltage_setpoint,
  input wire logic amp_loop_active,
  input wire logic volt_loop_active,
  input wire logic [31:0] loop_target_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence rd_q_s;
    req.valid && !req.write && req.index == load_regs_pkg::IDX_QUESTIONABLE_STATUS;
  endsequence
  sequence wr_s(logic [15:0] i);
    req.valid && req.write && req.index == i;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  answer_due_a: assert property (req.valid |=> rsp.done)
    else $error("answer missing");
  idle_quiet_a: assert property (!req.valid |=> !rsp.done && rsp.rdata == 32'h0000_0000)
    else $error("answer without request");
  refuse_zero_a: assert property (rsp.fault |-> rsp.done && rsp.rdata == 32'h0000_0000)
    else $error("refusal carries data");
  soft_or_a: assert property (rd_q_s |=> rsp.rdata[11] == |rsp.rdata[3:1])
    else $error("soft summary wrong");
  hard_or_a: assert property (rd_q_s |=> rsp.rdata[12] == (rsp.rdata[0] | (|rsp.rdata[6:4])))
    else $error("hard summary wrong");
  quest_spare_a: assert property (rd_q_s |=> rsp.rdata[31:16] == 16'h0000 && !rsp.fault)
    else $error("spare bits set");
  mode_bits_a: assert property (rd_q_s |=>
    rsp.rdata[7] == ($past(reg_mode) == load_regs_pkg::MODE_CC) &&
    rsp.rdata[8] == ($past(reg_mode) == load_regs_pkg::MODE_CV))
    else $error("mode bits wrong");
  cur_wr_a: assert property (wr_s(load_regs_pkg::IDX_CURRENT_SETPOINT_WR) |=>
    current_setpoint == $past(req.wdata)) else $error("current setpoint not taken");
  volt_wr_a: assert property (wr_s(load_regs_pkg::IDX_VOLTAGE_SETPOINT_WR) |=>
    voltage_setpoint == $past(req.wdata)) else $error("voltage setpoint not taken");
  loop_sel_a: assert property (amp_loop_active == (reg_mode == load_regs_pkg::MODE_CC) &&
    volt_loop_active == (reg_mode == load_regs_pkg::MODE_CV)) else $error("loop select wrong");
  loop_tgt_a: assert property (reg_mode == load_regs_pkg::MODE_CV |=>
    loop_target_q == $past(voltage_setpoint)) else $error("loop target wrong");
  amp_tgt_a: assert property (reg_mode == load_regs_pkg::MODE_CC |=>
    loop_target_q == $past(current_setpoint)) else $error("current loop target wrong");
  other_modes_a: assert property (rd_q_s |=>
    rsp.rdata[9] == ($past(reg_mode) == load_regs_pkg::MODE_CR) &&
    rsp.rdata[10] == ($past(reg_mode) == load_regs_pkg::MODE_CP))
    else $error("resistance or power mode bit wrong");
endmodule : load_regs_sva

bind load_status_setpoint_regs load_regs_sva chk (.clk(clk), .arst_n(arst_n), .req(req),
  .rsp(rsp), .reg_mode(reg_mode), .current_setpoint(current_setpoint),
  .voltage_setpoint(voltage_setpoint), .amp_loop_active(amp_loop_active),
  .volt_loop_active(volt_loop_active), .loop_target_q(loop_target_q));

// *** fieldbus_host.sv ***
/*
  Host model issuing object accesses on the request port.
  Assumes its tasks are called at the falling edge of clk.
*/
`timescale 1ns/1ps

module fieldbus_host (
  input wire logic clk,
  output load_regs_pkg::obj_req_t req
);
  initial req = '0;
  // Holds one request for one cycle; another call may follow at once.
  task automatic access(input logic w, input logic [15:0] i, input logic [31:0] d);
    req = '{valid: 1'b1, write: w, index: i, wdata: d};
    @(negedge clk);
  endtask : access
  task automatic idle();
    req = '0;
    @(negedge clk);
  endtask : idle
endmodule : fieldbus_host

// *** load_status_setpoint_regs_tb.sv ***
/*
  Random object traffic against the bank, scored through a queue of expected answers.
  Assumes the package, the host model and the checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module load_status_setpoint_regs_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sen = 1'b0;
  logic alp, vlp, w;
  load_regs_pkg::obj_req_t req;
  load_regs_pkg::obj_rsp_t rsp;
  load_regs_pkg::op_word0_t op0 = '0;
  load_regs_pkg::op_word1_t op1 = '0;
  load_regs_pkg::reg_mode_t mode = load_regs_pkg::MODE_NONE;
  logic [31:0] amps = '0, volts = '0, sv = '0, sp_c = '0, sp_v = '0, r = 32'hb25f_b847;
  logic [31:0] csp, vsp, tgt;
  logic [32:0] e;
  logic [32:0] exq[$];
  logic [15:0] i;
  logic [15:0] idx[10] = '{16'h200b, 16'h200d, 16'h200e, 16'h2101, 16'h2102, 16'h2201,
    16'h2202, 16'h2203, 16'h2204, 16'h2000};
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////////////////////
  load_status_setpoint_regs dut (.clk(clk), .arst_n(arst_n), .req(req), .rsp(rsp),
    .op0_cond(op0), .op1_cond(op1), .reg_mode(mode), .terminal_amps(amps),
    .terminal_volts(volts), .sense_volts(sv), .sense_engaged(sen), .current_setpoint(csp),
    .voltage_setpoint(vsp), .amp_loop_active(alp), .volt_loop_active(vlp), .loop_target_q(tgt));
  fieldbus_host host (.clk(clk), .req(req));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  // Expected answer; also tracks the setpoints that a write changes.
  function automatic logic [32:0] expect_rsp(logic wr, logic [15:0] x, logic [31:0] d);
    logic [15:0] q;
    logic [31:0] v;
    q[6:0] = {op0[7], |{op0[18], op0[23], op0[27], op1[7:4]}, op0[16], op0[6:4], op0[17]};
    q[10:7] = {mode == load_regs_pkg::MODE_CP, mode == load_regs_pkg::MODE_CR,
      mode == load_regs_pkg::MODE_CV, mode == load_regs_pkg::MODE_CC};
    q[11] = |q[3:1];
    q[12] = q[0] | (|q[6:4]);
    q[15:13] = {op0[26], op1[0] | op1[1], op0[20]};
    case (x)
      16'h200b: v = {16'h0000, q};
      16'h200d: v = op0 & 32'h7fdf_fff3;
      16'h200e: v = op1 & 32'h0003_00f7;
      16'h2101: v = amps;
      16'h2102: v = sen ? sv : volts;
      16'h2201, 16'h2202: v = sp_c;
      16'h2203, 16'h2204: v = sp_v;
      default: return {1'b1, 32'h0000_0000};
    endcase
    if (!wr) return {1'b0, v};
    if (x == 16'h2201) sp_c = d;
    else if (x == 16'h2203) sp_v = d;
    else return {1'b1, 32'h0000_0000};
    return {1'b0, 32'h0000_0000};
  endfunction : expect_rsp
  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      summarize();
    end
  end
  always @(negedge clk) begin
    if (rsp.done === 1'b1) begin
      if (exq.size() == 0) error_cnt++;
      else begin
        e = exq.pop_front();
        `CHK({rsp.fault, rsp.rdata}, e)
      end
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    for (int k = 0; k < 3000; k++) begin
      r = nx(r);
      if (r[3:0] == 4'h0) host.idle();
      if (r[31]) begin
        op0 = r;
        op1 = {r[15:0], r[31:16]} ^ 32'ha5a5_5a5a;
        mode = load_regs_pkg::reg_mode_t'(r[7:0] % 5);
        amps = ~r;
        volts = r ^ 32'h0f0f_0f0f;
        sv = {r[7:0], r[31:8]};
        sen = r[5];
      end
      i = idx[r[11:8] % 10];
      w = r[12];
      exq.push_back(expect_rsp(w, i, {r[15:0], r[31:16]}));
      host.access(w, i, {r[15:0], r[31:16]});
    end
    host.idle();
    repeat (3) @(negedge clk);
    `CHK(exq.size(), 0)
    summarize();
  end
endmodule : load_status_setpoint_regs_tb
